/* design/usbp_port_ctl.v */
/*
 * Upstream-port control, device addressing and endpoint fifo placement
 * for a full-speed function controller, with the shared data ram.
 * Assumes a classic Wishbone master for firmware, and a serial engine that
 * supplies line drive, activity events, bus reset and received fifo bytes.
 */
// Functional notes
// - force code 000 leaves the upstream transceiver to the serial engine.
// - codes 001, 010, 011 drive J, K and SE0 on the lines.
// - codes 100 to 111 drive low, D+ hiz, D- hiz, both hiz.
// - reset clears every stored bit of port status and control; the two pin bits still follow the pins.
// - any non-idle upstream event sets the sticky activity bit; only engine sets.
// - writing 0 clears activity, writing 1 keeps it.
// - two read-only bits show present D+ and D- pin levels.
// - reset clears device address to zero and disabled.
// - no response at the device address until its enable bit is set.
// - status bit 7 picks fifo sizes, bit 6 picks endpoint count.
// - small layout: 8-byte fifos at f8, f0, e8, and e0, d8 if counted.
// - large layout: ep0 8 at b8, ep1/ep2 32 at c0/e0, ep3/ep4 at a8/b0.
// - fifo space unused by the layout stays plain firmware ram.
// - engine fifo writes own the data bus, stalling the cpu three cycles per byte.
// - endpoint 0 is the bidirectional control endpoint; five endpoints at most.
// - enumeration starts at address 0; firmware answers through the fifos.
// - a usb bus reset clears the device address register.
`include "usbp_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module usbp_port_ctl (
    input wire REF_CLK,
    input wire RESETN,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [11:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    input wire DP_IN,
    input wire DM_IN,
    output reg DP_OUT,
    output reg DP_OE_N,
    output reg DM_OUT,
    output reg DM_OE_N,
    input wire SIE_DP_OUT,
    input wire SIE_DM_OUT,
    input wire SIE_OE_N,
    input wire SIE_BUS_EVENT,
    input wire SIE_BUS_RESET,
    input wire [6:0] TOKEN_ADDR,
    output wire TOKEN_HIT,
    output wire [6:0] DEV_ADDR,
    output wire DEV_ADDR_EN,
    output wire [4:0] EP_ACTIVE,
    input wire SIE_WR_VALID,
    output wire SIE_WR_READY,
    input wire [2:0] SIE_WR_EP,
    input wire [4:0] SIE_WR_IDX,
    input wire [7:0] SIE_WR_DATA,
    output wire SIE_WR_DROP
);
    reg [7:0] dev_addr;
    reg fifo_size;
    reg ep_count;
    reg bus_act;
    reg [2:0] force_code;
    reg [1:0] sie_busy;
    reg ram_pend;
    reg sie_we;
    reg [7:0] sie_addr;
    reg [7:0] sie_data;
    reg [2:0] next_force;
    wire [7:0] ram_q;
    wire wb_req;
    wire is_ram;
    wire sel_da;
    wire sel_sc;
    wire wr_sc;
    wire wr_da;
    wire cpu_ram_en;
    wire sie_take;
    wire sie_ok;
    wire [8:0] sie_base;
    wire [7:0] port_sc;
    wire ram_en;
    wire ram_we;
    wire [7:0] ram_addr;
    wire [7:0] ram_wdata;

    // fifo start address for an endpoint under a layout, with a valid flag on top
    function [8:0] ep_base;
        input size;
        input count;
        input [2:0] ep;
        begin
            ep_base = 9'h000;
            case (ep)
                3'h0: ep_base = {1'b1, size ? `USBP_L_EP0 : `USBP_S_EP0};
                3'h1: ep_base = {1'b1, size ? `USBP_L_EP1 : `USBP_S_EP1};
                3'h2: ep_base = {1'b1, size ? `USBP_L_EP2 : `USBP_S_EP2};
                3'h3: ep_base = {count, size ? `USBP_L_EP3 : `USBP_S_EP3};
                3'h4: ep_base = {count, size ? `USBP_L_EP4 : `USBP_S_EP4};
                default: ep_base = 9'h000;
            endcase
        end
    endfunction

    // fifo length in bytes for an endpoint under a layout
    function [5:0] ep_len;
        input size;
        input [2:0] ep;
        begin
            if (size && (ep == 3'h1 || ep == 3'h2)) begin
                ep_len = `USBP_FIFO_LARGE;
            end else begin
                ep_len = `USBP_FIFO_SMALL;
            end
        end
    endfunction

    assign port_sc = {fifo_size, ep_count, DP_IN, DM_IN, bus_act, force_code};

    assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign is_ram = WB_ADR_I[`USBP_RAM_SEL_BIT];
    assign sel_da = !is_ram && (WB_ADR_I == `USBP_ADR_DEV_ADDR);
    assign sel_sc = !is_ram && (WB_ADR_I == `USBP_ADR_PORT_SC);
    assign wr_sc = wb_req && WB_WE_I && WB_SEL_I[0] && sel_sc;
    assign wr_da = wb_req && WB_WE_I && WB_SEL_I[0] && sel_da;

    // cpu ram access waits while the engine owns the bus
    assign cpu_ram_en = wb_req && is_ram && !ram_pend && (sie_busy == 2'h0);
    assign SIE_WR_READY = (sie_busy == 2'h0) && !cpu_ram_en;
    assign sie_take = SIE_WR_VALID && SIE_WR_READY;
    // layout is read live, so a layout write applies at once
    assign sie_base = ep_base(fifo_size, ep_count, SIE_WR_EP);
    assign sie_ok = sie_base[8] && ({1'b0, SIE_WR_IDX} < ep_len(fifo_size, SIE_WR_EP));
    assign SIE_WR_DROP = sie_take && !sie_ok;

    assign ram_en = cpu_ram_en || sie_we;
    assign ram_we = sie_we || (WB_WE_I && WB_SEL_I[0]);
    assign ram_addr = sie_we ? sie_addr : WB_ADR_I[9:2];
    assign ram_wdata = sie_we ? sie_data : WB_DAT_I[7:0];

    usbp_ram u_ram (
        .clk(REF_CLK),
        .en(ram_en),
        .we(ram_we),
        .addr(ram_addr),
        .wdata(ram_wdata),
        .q(ram_q)
    );

    // engine byte: one write cycle, then the bus stays taken to make three
    always @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sie_busy <= 2'h0;
            sie_we <= 1'b0;
            sie_addr <= 8'h00;
            sie_data <= 8'h00;
        end else begin
            sie_we <= 1'b0;
            if (sie_take && sie_ok) begin
                sie_busy <= `USBP_SIE_STALL;
                sie_we <= 1'b1;
                sie_addr <= sie_base[7:0] + {3'h0, SIE_WR_IDX};
                sie_data <= SIE_WR_DATA;
            end else if (sie_busy != 2'h0) begin
                sie_busy <= sie_busy - 2'h1;
            end
        end
    end

    // bus slave: registers answer one cycle after the request, ram two
    always @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
            ram_pend <= 1'b0;
        end else begin
            WB_ACK_O <= 1'b0;
            if (ram_pend) begin
                ram_pend <= 1'b0;
                WB_ACK_O <= 1'b1;
                WB_DAT_O <= {24'h000000, ram_q};
            end else if (cpu_ram_en) begin
                ram_pend <= 1'b1;
            end else if (wb_req && !is_ram) begin
                WB_ACK_O <= 1'b1;
                if (sel_da) begin
                    WB_DAT_O <= {24'h000000, dev_addr};
                end else if (sel_sc) begin
                    WB_DAT_O <= {24'h000000, port_sc};
                end else begin
                    WB_DAT_O <= 32'h00000000;
                end
            end
        end
    end

    // port status and control
    always @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            fifo_size <= 1'b0;
            ep_count <= 1'b0;
            bus_act <= 1'b0;
            force_code <= 3'h0;
        end else begin
            if (wr_sc) begin
                fifo_size <= WB_DAT_I[`USBP_SC_SIZE];
                ep_count <= WB_DAT_I[`USBP_SC_COUNT];
                force_code <= WB_DAT_I[`USBP_SC_FORCE_HI:`USBP_SC_FORCE_LO];
            end
            // an event in the clearing cycle wins over the clear
            if (SIE_BUS_EVENT) begin
                bus_act <= 1'b1;
            end else if (wr_sc && !WB_DAT_I[`USBP_SC_ACT]) begin
                bus_act <= 1'b0;
            end
        end
    end

    // device address; a usb bus reset clears it as chip reset does
    always @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            dev_addr <= `USBP_RST_DEV_ADDR;
        end else if (SIE_BUS_RESET) begin
            dev_addr <= `USBP_RST_DEV_ADDR;
        end else if (wr_da) begin
            dev_addr <= WB_DAT_I[7:0];
        end
    end

    assign DEV_ADDR = dev_addr[6:0];
    assign DEV_ADDR_EN = dev_addr[`USBP_DA_EN];
    // before enabling, only default address 0 is answered
    assign TOKEN_HIT = DEV_ADDR_EN ? (TOKEN_ADDR == DEV_ADDR) : (TOKEN_ADDR == 7'h00);
    assign EP_ACTIVE = {ep_count, ep_count, 3'h7};

    always @* begin
        next_force = force_code;
    end

    // line drive, registered; oe_n low means the pin is driven
    always @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            DP_OUT <= 1'b0;
            DM_OUT <= 1'b0;
            DP_OE_N <= 1'b1;
            DM_OE_N <= 1'b1;
        end else begin
            case (next_force)
                `USBP_FRC_NONE: begin
                    DP_OUT <= SIE_DP_OUT;
                    DM_OUT <= SIE_DM_OUT;
                    DP_OE_N <= SIE_OE_N;
                    DM_OE_N <= SIE_OE_N;
                end
                `USBP_FRC_J: begin
                    DP_OUT <= 1'b1;
                    DM_OUT <= 1'b0;
                    DP_OE_N <= 1'b0;
                    DM_OE_N <= 1'b0;
                end
                `USBP_FRC_K: begin
                    DP_OUT <= 1'b0;
                    DM_OUT <= 1'b1;
                    DP_OE_N <= 1'b0;
                    DM_OE_N <= 1'b0;
                end
                `USBP_FRC_SE0, `USBP_FRC_LOW: begin
                    DP_OUT <= 1'b0;
                    DM_OUT <= 1'b0;
                    DP_OE_N <= 1'b0;
                    DM_OE_N <= 1'b0;
                end
                `USBP_FRC_DPZ: begin
                    DP_OUT <= 1'b0;
                    DM_OUT <= 1'b0;
                    DP_OE_N <= 1'b1;
                    DM_OE_N <= 1'b0;
                end
                `USBP_FRC_DMZ: begin
                    DP_OUT <= 1'b0;
                    DM_OUT <= 1'b0;
                    DP_OE_N <= 1'b0;
                    DM_OE_N <= 1'b1;
                end
                default: begin
                    DP_OUT <= 1'b0;
                    DM_OUT <= 1'b0;
                    DP_OE_N <= 1'b1;
                    DM_OE_N <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* design/usbp_ram.v */
/*
 * 256 x 8 data ram, single port, read data from a register.
 * Assumes one requester per cycle; the arbiter outside guarantees it.
 */
`timescale 1ns/1ps
`default_nettype none
module usbp_ram (
    input wire clk,
    input wire en,
    input wire we,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    output reg [7:0] q
);
    reg [7:0] mem [0:255];

    always @(posedge clk) begin
        if (en) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            q <= mem[addr];
        end
    end
endmodule
`default_nettype wire

/* shared/usbp_consts.vh */
/*
 * Constants of the upstream-port and device-address block: register
 * offsets, field positions, reset values, endpoint FIFO layouts and timing.
 * Assumes it is included by bare name from the design files.
 */
`ifndef USBP_CONSTS_VH
`define USBP_CONSTS_VH

// register indices; byte address on the bus is four times the index
`define USBP_IDX_DEV_ADDR 8'h10
`define USBP_IDX_PORT_SC 8'h1f
`define USBP_ADR_DEV_ADDR 12'h040
`define USBP_ADR_PORT_SC 12'h07c
// data ram window: byte address 0x400 + 4 * ram index
`define USBP_RAM_SEL_BIT 10

`define USBP_RST_DEV_ADDR 8'h00
`define USBP_RST_PORT_SC 8'h00

// port status and control fields
`define USBP_SC_SIZE 7
`define USBP_SC_COUNT 6
`define USBP_SC_DP 5
`define USBP_SC_DM 4
`define USBP_SC_ACT 3
`define USBP_SC_FORCE_HI 2
`define USBP_SC_FORCE_LO 0
// device address fields
`define USBP_DA_EN 7

// line-force codes
`define USBP_FRC_NONE 3'h0
`define USBP_FRC_J 3'h1
`define USBP_FRC_K 3'h2
`define USBP_FRC_SE0 3'h3
`define USBP_FRC_LOW 3'h4
`define USBP_FRC_DPZ 3'h5
`define USBP_FRC_DMZ 3'h6
`define USBP_FRC_ZZ 3'h7

// fifo layout, small fifos
`define USBP_S_EP0 8'hf8
`define USBP_S_EP1 8'hf0
`define USBP_S_EP2 8'he8
`define USBP_S_EP3 8'he0
`define USBP_S_EP4 8'hd8
// fifo layout, large fifos
`define USBP_L_EP0 8'hb8
`define USBP_L_EP1 8'hc0
`define USBP_L_EP2 8'he0
`define USBP_L_EP3 8'ha8
`define USBP_L_EP4 8'hb0
`define USBP_FIFO_SMALL 6'h08
`define USBP_FIFO_LARGE 6'h20

// serial engine owns the data bus this many cycles per byte
`define USBP_SIE_STALL 2'h3

`endif

/* test/tb_usbp_port_ctl.sv */
/*
 * Self-checking bench for usbp_port_ctl: registers, line force, addressing, fifos.
 * Assumes the host model on the pair and the bench acting as firmware and engine.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin error_cnt++; \
    $display("unexpected at %0t: %h vs %h", $time, g, x); end end
module tb_usbp_port_ctl;
    reg clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, s_dp = 0, s_dm = 0, s_oe_n = 1, ev = 0, brst = 0, enum_done = 0;
    reg [11:0] adr = 0;
    reg [3:0] sel = 0;
    reg [31:0] dat = 0, r;
    reg [6:0] asg = 0;
    reg wv = 0;
    reg [2:0] wep = 0;
    reg [4:0] widx = 0, x;
    reg [7:0] wdat = 0, d;
    wire [31:0] rdat;
    wire [6:0] tok, da;
    wire [4:0] epa;
    wire ack, dp_out, dp_oe_n, dm_out, dm_oe_n, dp_in, dm_in, hit, dae, wr_ready, drop;
    integer error_cnt = 0, num_checks = 0, i, m, e, n;
    always #12.5 clk = ~clk;
    usbp_port_ctl i_dut (.REF_CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .DP_IN(dp_in),
        .DM_IN(dm_in), .DP_OUT(dp_out), .DP_OE_N(dp_oe_n), .DM_OUT(dm_out), .DM_OE_N(dm_oe_n),
        .SIE_DP_OUT(s_dp), .SIE_DM_OUT(s_dm), .SIE_OE_N(s_oe_n), .SIE_BUS_EVENT(ev), .SIE_BUS_RESET(brst),
        .TOKEN_ADDR(tok), .TOKEN_HIT(hit), .DEV_ADDR(da), .DEV_ADDR_EN(dae), .EP_ACTIVE(epa),
        .SIE_WR_VALID(wv), .SIE_WR_READY(wr_ready), .SIE_WR_EP(wep), .SIE_WR_IDX(widx),
        .SIE_WR_DATA(wdat), .SIE_WR_DROP(drop));
    usbp_host_model i_host (.dp_out(dp_out), .dp_oe_n(dp_oe_n), .dm_out(dm_out), .dm_oe_n(dm_oe_n),
        .enumerated(enum_done), .assigned(asg), .dp_in(dp_in), .dm_in(dm_in), .token_addr(tok));
    function [7:0] base(input [1:0] md, input [2:0] ep);
        if (!md[1]) base = 8'hf8 - {2'b00, ep, 3'b000};
        else case (ep)
            3'd0: base = 8'hb8;
            3'd1: base = 8'hc0;
            3'd2: base = 8'he0;
            3'd3: base = 8'ha8;
            default: base = 8'hb0;
        endcase
    endfunction
    function [5:0] fsz(input [1:0] md, input [2:0] ep);
        fsz = (md[1] && (ep == 3'd1 || ep == 3'd2)) ? 6'h20 : 6'h08;
    endfunction
    // released D+ reads high, released D- reads low
    function [1:0] pins(input [2:0] f, input sdp, input sdm, input soe);
        case (f)
            3'h0: pins = soe ? 2'b10 : {sdp, sdm};
            3'h1, 3'h5, 3'h7: pins = 2'b10;
            3'h2: pins = 2'b01;
            default: pins = 2'b00;
        endcase
    endfunction
    task wb(input w, input [11:0] a, input [7:0] v);
        begin
            n = 0; cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'h1; dat <= {24'h0, v};
            @(posedge clk);
            while (ack !== 1'b1 && n < 40) begin n++; @(posedge clk); end
            if (n == 40) begin
                error_cnt++;
                $display("unexpected at %0t: bus answer missing", $time);
            end
            r = rdat; cyc <= 0; stb <= 0; we <= 0;
            @(posedge clk);
        end
    endtask
    task send(input [2:0] ep, input [4:0] idx, input [7:0] v, input exp_drop);
        begin
            n = 0; wv <= 1; wep <= ep; widx <= idx; wdat <= v;
            @(posedge clk);
            while (wr_ready !== 1'b1 && n < 40) begin n++; @(posedge clk); end
            if (n == 40) begin
                error_cnt++;
                $display("unexpected at %0t: engine byte never taken", $time);
            end
            `CHK(drop, exp_drop)
            wv <= 0;
            repeat (4) @(posedge clk);
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        #(25 * 30000);
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up;
    end
    initial begin
        e = $urandom(51);
        repeat (10) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        wb(0, 12'h040, 0); `CHK(r[7:0], 8'h00)
        wb(0, 12'h07c, 0); `CHK(r[7:0], {2'b00, pins(3'h0, s_dp, s_dm, s_oe_n), 4'h0})
        wb(0, 12'h3f0, 0); `CHK(r, 32'h0)
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            s_dp <= $urandom; s_dm <= $urandom; s_oe_n <= $urandom;
            // pin-level bits written as ones must still read the live pins
            wb(1, 12'h07c, 8'h30 | i); wb(0, 12'h07c, 0);
            d = {2'b00, pins(i[2:0], s_dp, s_dm, s_oe_n), 1'b0, i[2:0]};
            `CHK(r[7:0], d)
        end
        wb(1, 12'h07c, 8'h00);
        $display("test line force done");
        ev <= 1; @(posedge clk); ev <= 0; @(posedge clk);
        wb(0, 12'h07c, 0); `CHK(r[3], 1'b1)
        wb(1, 12'h07c, 8'h08); wb(0, 12'h07c, 0); `CHK(r[3], 1'b1)
        wb(1, 12'h07c, 8'h00); wb(0, 12'h07c, 0); `CHK(r[3], 1'b0)
        // event only at the edge that takes the clearing write: the set must win
        ev <= 1;
        fork
            wb(1, 12'h07c, 8'h00);
            begin
                @(posedge clk);
                ev <= 0;
            end
        join
        wb(0, 12'h07c, 0);
        `CHK(r[3], 1'b1)
        $display("test activity done");
        `CHK(hit, 1'b1)
        e = $urandom_range(127, 1); asg <= e[6:0]; enum_done <= 1;
        wb(1, 12'h040, {1'b0, e[6:0]}); `CHK(hit, 1'b0)
        wb(1, 12'h040, {1'b1, e[6:0]}); `CHK(hit, 1'b1)
        `CHK({dae, da}, {1'b1, e[6:0]})
        wb(0, 12'h040, 0); `CHK(r[7:0], {1'b1, e[6:0]})
        brst <= 1; @(posedge clk); brst <= 0; @(posedge clk);
        wb(0, 12'h040, 0); `CHK(r[7:0], 8'h00)
        `CHK({dae, da}, 8'h00)
        enum_done <= 0;
        $display("test address done");
        for (m = 0; m < 4; m++) begin
            // each pass writes one fifo size and endpoint count setting before any engine byte is sent
            wb(1, 12'h07c, {m[1:0], 6'h00});
            `CHK(epa, {m[0], m[0], 3'h7})
            for (e = 0; e < 5; e++) begin
                d = $urandom; x = $urandom % fsz(m[1:0], e[2:0]);
                send(e[2:0], x, d, !(e < 3 || m[0]));
                if (e < 3 || m[0]) begin
                    wb(0, {2'b01, base(m[1:0], e[2:0]) + {3'b000, x}, 2'b00}, 0);
                    `CHK(r[7:0], d)
                end
                send(e[2:0], 5'd8, $urandom, !(e < 3 || m[0]) || fsz(m[1:0], e[2:0]) == 6'h08);
            end
        end
        wb(1, 12'h07c, 8'h00); wb(1, 12'h760, 8'h5a); wb(0, 12'h760, 0); `CHK(r[7:0], 8'h5a)
        $display("test fifo layout done");
        wrap_up;
    end
endmodule
`default_nettype wire

/* test/usbp_host_model.sv */
/*
 * Host side of the upstream pair: resolves both lines and picks token address.
 * Assumes a pull-up on D+ and a pull-down on D-; host never drives here.
 */
`timescale 1ns/1ps
`default_nettype none
module usbp_host_model (
    input wire dp_out,
    input wire dp_oe_n,
    input wire dm_out,
    input wire dm_oe_n,
    input wire enumerated,
    input wire [6:0] assigned,
    output wire dp_in,
    output wire dm_in,
    output wire [6:0] token_addr
);
    assign dp_in = dp_oe_n ? 1'b1 : dp_out;
    assign dm_in = dm_oe_n ? 1'b0 : dm_out;
    // before an address is assigned every token goes to address zero
    assign token_addr = enumerated ? assigned : 7'h00;
endmodule
`default_nettype wire

/* test/usbp_port_props.sv */
/*
 * Checker for the upstream-port block: line force, addressing, fifo stall.
 * Assumes it is bound to usbp_port_ctl and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none
module usbp_port_props (
    input wire REF_CLK,
    input wire RESETN,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [11:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    input wire WB_ACK_O,
    input wire DP_OUT,
    input wire DP_OE_N,
    input wire DM_OUT,
    input wire DM_OE_N,
    input wire SIE_DP_OUT,
    input wire SIE_DM_OUT,
    input wire SIE_OE_N,
    input wire SIE_BUS_RESET,
    input wire [6:0] TOKEN_ADDR,
    input wire TOKEN_HIT,
    input wire [6:0] DEV_ADDR,
    input wire DEV_ADDR_EN,
    input wire [4:0] EP_ACTIVE,
    input wire SIE_WR_VALID,
    input wire SIE_WR_READY,
    input wire SIE_WR_DROP
);
    // shadow of the status byte, updated on the edge that takes the write
    reg [7:0] sc;
    wire take = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0] && WB_ADR_I == 12'h07c;
    always @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) sc <= 8'h00;
        else if (take) sc <= WB_DAT_I[7:0];
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    sequence s_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ADR_I[10];
    endsequence
    sequence s_busy;
        !SIE_WR_READY [*3] ##1 SIE_WR_READY;
    endsequence
    a_force_pass: assert property ($past(RESETN) && $past(sc[2:0]) == 3'h0 |->
        DP_OUT == $past(SIE_DP_OUT) && DM_OUT == $past(SIE_DM_OUT) && DP_OE_N == $past(SIE_OE_N)
        && DM_OE_N == $past(SIE_OE_N)) else $error("line drive not passed through");
    a_force_drive: assert property ($past(RESETN) && $past(sc[2:0]) inside {3'h1, 3'h2, 3'h3} |->
        !DP_OE_N && !DM_OE_N && DP_OUT == ($past(sc[2:0]) == 3'h1) && DM_OUT == ($past(sc[2:0]) == 3'h2))
        else $error("forced line state wrong");
    a_force_hiz: assert property ($past(RESETN) && $past(sc[2]) |-> DP_OE_N == $past(sc[0]) &&
        DM_OE_N == $past(sc[1]) && (DP_OE_N || !DP_OUT) && (DM_OE_N || !DM_OUT)) else $error("forced hiz wrong");
    a_addr_chip: assert property ($rose(RESETN) |-> DEV_ADDR == 7'h00 && !DEV_ADDR_EN)
        else $error("address not cleared by reset");
    a_addr_bus: assert property (SIE_BUS_RESET |=> DEV_ADDR == 7'h00 && !DEV_ADDR_EN)
        else $error("address not cleared by bus reset");
    a_token_match: assert property (TOKEN_HIT == (DEV_ADDR_EN ? TOKEN_ADDR == DEV_ADDR :
        TOKEN_ADDR == 7'h00)) else $error("token match wrong");
    a_ep_count: assert property (EP_ACTIVE == {sc[6], sc[6], 3'h7})
        else $error("active endpoints wrong");
    a_stall_three: assert property (SIE_WR_VALID && SIE_WR_READY && !SIE_WR_DROP |=> s_busy)
        else $error("engine stall not three cycles");
    a_drop_free: assert property (SIE_WR_VALID && SIE_WR_READY && SIE_WR_DROP |=> SIE_WR_READY)
        else $error("dropped byte stalled");
    a_reg_ack: assert property (s_req |=> WB_ACK_O) else $error("register ack late");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
endmodule
bind usbp_port_ctl usbp_port_props i_props (.*);
`default_nettype wire
